// ---- shared/dcff_map.svh ----
// Purpose: constants of the dual-clock fwft fifo core
// Assumes: 1,024-deep variant, 36-bit words
// Notes: offsets of the host command registers are byte addresses
`ifndef DCFF_MAP_SVH
`define DCFF_MAP_SVH
// geometry
`define DCFF_DW        36
`define DCFF_AW        10
`define DCFF_PW        11
`define DCFF_DEPTH     11'h400
// offset presets and limits
`define DCFF_PRE_LOW   10'h008
`define DCFF_PRE_HIGH  10'h040
`define DCFF_OFF_MIN   10'h001
`define DCFF_OFF_MAX   10'h3FC
`define DCFF_OFF_RST   10'h000
// serial programming length and parallel load count
`define DCFF_SER_BITS  5'h14
`define DCFF_PLOAD_N   2'h2
// reset hold in clock edges
`define DCFF_RST_HOLD  3'h4
// host command registers
`define DCFF_REG_CTRL  8'h00
`define DCFF_REG_PUSH  8'h04
`define DCFF_REG_POP   8'h08
`define DCFF_REG_DATA  8'h0C
`define DCFF_REG_STAT  8'h10
`define DCFF_REG_SER   8'h14
`endif

// ---- shared/dcff_pkg.sv ----
// Purpose: types shared by both ends of the fifo link
// Assumes: constants come from dcff_map.svh
// Notes: offset mode codes equal the strap pair {sel1, sel0}
`include "dcff_map.svh"
package dcff_pkg;
  // offset programming mode chosen at reset release
  typedef enum logic [1:0] {
    OM_PARALLEL = 2'h0,
    OM_PRE_LOW  = 2'h1,
    OM_PRE_HIGH = 2'h2,
    OM_SERIAL   = 2'h3
  } dcff_mode_t;
  // setup sequence of the device
  typedef enum logic [1:0] {
    CS_STRAP = 2'h0,
    CS_SHIFT = 2'h1,
    CS_ARM   = 2'h2,
    CS_RUN   = 2'h3
  } dcff_cfg_t;
endpackage

// ---- shared/dcff_if.sv ----
// Purpose: pin-level link between the fifo device and its controller
// Assumes: both ends share one clock
// Notes: the two data buses are resolved here from the output enables
`timescale 1ns/100ps
`include "dcff_map.svh"
interface dcff_if;
  import dcff_pkg::*;
  // reset and straps
  logic                 fifo_rst_n;
  logic                 flag_sel0_serial_data;
  logic                 flag_sel1_serial_load_n;
  // port a controls and data
  logic                 port_a_select_n;
  logic                 port_a_write_not_read;
  logic                 port_a_strobe;
  logic                 port_a_mail_select;
  logic [`DCFF_DW-1:0]  a_host_dout;
  logic                 a_host_oe;
  logic [`DCFF_DW-1:0]  a_dev_dout;
  logic                 a_dev_oe;
  logic [`DCFF_DW-1:0]  port_a_bus;
  // port b controls and data
  logic                 port_b_select_n;
  logic                 port_b_write_not_read;
  logic                 port_b_strobe;
  logic                 port_b_mail_select;
  logic [`DCFF_DW-1:0]  b_host_dout;
  logic                 b_host_oe;
  logic [`DCFF_DW-1:0]  b_dev_dout;
  logic                 b_dev_oe;
  logic [`DCFF_DW-1:0]  port_b_bus;
  // flags
  logic                 input_ready_flag;
  logic                 output_ready_flag;
  logic                 almost_empty_flag;
  logic                 almost_full_flag;
  logic                 mail_one_flag;
  logic                 mail_two_flag;

  // bus levels from the enables, floating bus reads as zero
  assign port_a_bus = a_host_oe ? a_host_dout : (a_dev_oe ? a_dev_dout : {`DCFF_DW{1'b0}});
  assign port_b_bus = b_host_oe ? b_host_dout : (b_dev_oe ? b_dev_dout : {`DCFF_DW{1'b0}});
  modport dev (
    input  fifo_rst_n, flag_sel0_serial_data, flag_sel1_serial_load_n,
    input  port_a_select_n, port_a_write_not_read, port_a_strobe, port_a_mail_select, port_a_bus,
    input  port_b_select_n, port_b_write_not_read, port_b_strobe, port_b_mail_select, port_b_bus,
    output a_dev_dout, a_dev_oe, b_dev_dout, b_dev_oe,
    output input_ready_flag, output_ready_flag, almost_empty_flag, almost_full_flag,
    output mail_one_flag, mail_two_flag
  );
  modport host (
    output fifo_rst_n, flag_sel0_serial_data, flag_sel1_serial_load_n,
    output port_a_select_n, port_a_write_not_read, port_a_strobe, port_a_mail_select,
    output port_b_select_n, port_b_write_not_read, port_b_strobe, port_b_mail_select,
    output a_host_dout, a_host_oe, b_host_dout, b_host_oe,
    input  port_a_bus, port_b_bus,
    input  input_ready_flag, output_ready_flag, almost_empty_flag, almost_full_flag,
    input  mail_one_flag, mail_two_flag
  );
endinterface // dcff_if

// ---- design/dcff_device.sv ----
// Purpose: fwft fifo device end, 1,024 x 36, with programmable offsets
// Assumes: both ports run on CLK; straps steady around reset release
// Notes: mailbox and retransmit are absent; mailbox flags stay high
// Functional notes
// - reset release strap picks offset setup mode
// - preset loads offsets, ready after two edges
// - parallel: first two writes load full, empty
// - parallel offset from low ten bus lines
// - serial programmer clamps offsets to 1 to 1,020
// - serial: one bit per edge while load low
// - serial order full msb first, empty lsb last
// - serial: ready rises edge after final bit
// - port a driven only when selected read
// - fifo write qualification on port a
// - port b driven only when selected read
// - fifo read qualification on port b
// - empty output register refills by itself
// - flags through two flops of own clock
// - output ready means fresh word, else ignore
// - read pointer advances per output load
// - new word appears third edge after write
// - write sync starts on edge after skew
// - input ready means free slot, else ignore
// - write pointer advances per accepted memory write
// - freed slot raises ready on second edge
// - read sync starts on edge after skew
// - reset clears pointers and sets flag levels
`timescale 1ns/100ps
`include "dcff_map.svh"
module dcff_device
  import dcff_pkg::*;
(
  // clock and reset
  input  wire logic              CLK,
  input  wire logic              RESET_N,
  // fifo link
  dcff_if.dev                    LINK,
  // offset readback
  output logic [`DCFF_AW-1:0]    EMPTY_OFFSET,
  output logic [`DCFF_AW-1:0]    FULL_OFFSET,
  output logic [1:0]             OFFSET_MODE
);

  //////////////////////////////////////////////////////////////////////////////
  // declarations
  logic                 rst_n;
  dcff_cfg_t            st_r;
  dcff_mode_t           mode_r;
  dcff_mode_t           strap;
  logic [4:0]           bit_cnt_r;
  logic [1:0]           pload_cnt_r;
  logic [`DCFF_AW-1:0]  empty_off_r;
  logic [`DCFF_AW-1:0]  full_off_r;
  logic [`DCFF_DW-1:0]  mem [0:(1<<`DCFF_AW)-1];
  logic [`DCFF_PW-1:0]  wptr_r;
  logic [`DCFF_PW-1:0]  wgray_r;
  logic [`DCFF_PW-1:0]  rptr_r;
  logic [`DCFF_PW-1:0]  rgray_r;
  logic [`DCFF_PW-1:0]  rg_s1_r;
  logic [`DCFF_PW-1:0]  rg_s2_r;
  logic [`DCFF_PW-1:0]  wg_s1_r;
  logic [`DCFF_PW-1:0]  wg_s2_r;
  logic [`DCFF_PW-1:0]  rsync_bin;
  logic [`DCFF_PW-1:0]  wsync_bin;
  logic [`DCFF_PW-1:0]  fill_a;
  logic [`DCFF_PW-1:0]  fill_b;
  logic [`DCFF_PW-1:0]  wptr_nxt;
  logic [`DCFF_PW-1:0]  rptr_nxt;
  logic                 full;
  logic                 ir;
  logic                 wr_go;
  logic                 mem_wr;
  logic                 rd_go;
  logic                 load;
  logic                 or_r;
  logic                 ae_r;
  logic                 af_r;
  logic [`DCFF_DW-1:0]  out_r;

  //////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [`DCFF_PW-1:0] bin2gray(input logic [`DCFF_PW-1:0] b);
    bin2gray = b ^ (b >> 1);
  endfunction
  function automatic logic [`DCFF_PW-1:0] gray2bin(input logic [`DCFF_PW-1:0] g);
    logic [`DCFF_PW-1:0] b;
    b = g;
    for (int i = `DCFF_PW-2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    gray2bin = b;
  endfunction

  // device is held in reset by the system reset or the link reset pin
  assign rst_n = RESET_N & LINK.fifo_rst_n;
  assign strap = dcff_mode_t'({LINK.flag_sel1_serial_load_n, LINK.flag_sel0_serial_data});

  //////////////////////////////////////////////////////////////////////////////
  // setup sequence after reset release
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      st_r   <= CS_STRAP;
      mode_r <= OM_PARALLEL;
    end else begin
      case (st_r)
        CS_STRAP: begin
          mode_r <= strap;
          st_r   <= (strap == OM_SERIAL) ? CS_SHIFT : CS_ARM;
        end
        CS_SHIFT: begin
          if (bit_cnt_r == `DCFF_SER_BITS) begin
            st_r <= CS_RUN;
          end
        end
        CS_ARM:   st_r <= CS_RUN;
        default:  st_r <= CS_RUN;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // offset registers: preset, serial shift or parallel load
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      empty_off_r <= `DCFF_OFF_RST;
      full_off_r  <= `DCFF_OFF_RST;
      bit_cnt_r   <= 5'h00;
      pload_cnt_r <= 2'h0;
    end else if (st_r == CS_STRAP) begin
      if (strap == OM_PRE_LOW) begin
        empty_off_r <= `DCFF_PRE_LOW;
        full_off_r  <= `DCFF_PRE_LOW;
      end else if (strap == OM_PRE_HIGH) begin
        empty_off_r <= `DCFF_PRE_HIGH;
        full_off_r  <= `DCFF_PRE_HIGH;
      end
      // only parallel mode diverts writes to the offsets
      pload_cnt_r <= (strap == OM_PARALLEL) ? 2'h0 : `DCFF_PLOAD_N;
    end else if (st_r == CS_SHIFT) begin
      if (!LINK.flag_sel1_serial_load_n && bit_cnt_r != `DCFF_SER_BITS) begin
        // full msb enters first and ends at the top of full
        {full_off_r, empty_off_r} <= {full_off_r[`DCFF_AW-2:0], empty_off_r,
                                      LINK.flag_sel0_serial_data};
        bit_cnt_r <= bit_cnt_r + 5'h01;
      end
    end else if (wr_go && pload_cnt_r != `DCFF_PLOAD_N) begin
      if (pload_cnt_r == 2'h0) begin
        full_off_r <= LINK.port_a_bus[`DCFF_AW-1:0];
      end else begin
        empty_off_r <= LINK.port_a_bus[`DCFF_AW-1:0];
      end
      pload_cnt_r <= pload_cnt_r + 2'h1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // port a: write side
  assign fill_a = wptr_r - rsync_bin;
  assign full   = (fill_a == `DCFF_DEPTH);
  // ready high only after setup and while a slot is free
  assign ir     = (st_r == CS_RUN) && !full;
  assign wr_go  = !LINK.port_a_select_n && !LINK.port_a_mail_select && LINK.port_a_write_not_read &&
                  LINK.port_a_strobe && ir;
  assign mem_wr = wr_go && (pload_cnt_r == `DCFF_PLOAD_N);
  assign wptr_nxt = wptr_r + {{(`DCFF_PW-1){1'b0}}, mem_wr};
  // memory array, no reset
  always_ff @(posedge CLK) begin
    if (mem_wr) begin
      mem[wptr_r[`DCFF_AW-1:0]] <= LINK.port_a_bus;
    end
  end

  // write pointer, binary and gray copies
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      wptr_r  <= {`DCFF_PW{1'b0}};
      wgray_r <= {`DCFF_PW{1'b0}};
    end else begin
      wptr_r  <= wptr_nxt;
      wgray_r <= bin2gray(wptr_nxt);
    end
  end

  // read pointer into write side: two stages, skew only delays a cycle
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      rg_s1_r <= {`DCFF_PW{1'b0}};
      rg_s2_r <= {`DCFF_PW{1'b0}};
    end else begin
      rg_s1_r <= rgray_r;
      rg_s2_r <= rg_s1_r;
    end
  end
  assign rsync_bin = gray2bin(rg_s2_r);

  // almost-full, low at or above depth minus offset
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      af_r <= 1'b1;
    end else begin
      af_r <= (fill_a < (`DCFF_DEPTH - {1'b0, full_off_r}));
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // port b: read side
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      wg_s1_r <= {`DCFF_PW{1'b0}};
      wg_s2_r <= {`DCFF_PW{1'b0}};
    end else begin
      wg_s1_r <= wgray_r;
      wg_s2_r <= wg_s1_r;
    end
  end
  assign wsync_bin = gray2bin(wg_s2_r);
  assign fill_b    = wsync_bin - rptr_r;
  assign rd_go     = !LINK.port_b_select_n && !LINK.port_b_mail_select && LINK.port_b_write_not_read &&
                     LINK.port_b_strobe && or_r;
  // refill when empty or when a read empties the register
  assign load      = (fill_b != {`DCFF_PW{1'b0}}) && (!or_r || rd_go);
  assign rptr_nxt  = rptr_r + {{(`DCFF_PW-1){1'b0}}, load};

  // read pointer, binary and gray copies
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      rptr_r  <= {`DCFF_PW{1'b0}};
      rgray_r <= {`DCFF_PW{1'b0}};
    end else begin
      rptr_r  <= rptr_nxt;
      rgray_r <= bin2gray(rptr_nxt);
    end
  end

  // output register and output-ready flag
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      out_r <= {`DCFF_DW{1'b0}};
      or_r  <= 1'b0;
    end else if (load) begin
      out_r <= mem[rptr_r[`DCFF_AW-1:0]];
      or_r  <= 1'b1;
    end else if (rd_go) begin
      or_r  <= 1'b0;
    end
  end

  // almost-empty, low at or below the offset
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      ae_r <= 1'b0;
    end else begin
      ae_r <= (fill_b > {1'b0, empty_off_r});
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // pins and readback
  assign LINK.a_dev_oe           = !LINK.port_a_select_n && !LINK.port_a_write_not_read;
  assign LINK.a_dev_dout         = {`DCFF_DW{1'b0}}; // no mailbox word to return
  assign LINK.b_dev_oe           = !LINK.port_b_select_n && LINK.port_b_write_not_read;
  assign LINK.b_dev_dout         = out_r;
  assign LINK.input_ready_flag   = ir;
  assign LINK.output_ready_flag  = or_r;
  assign LINK.almost_empty_flag  = ae_r;
  assign LINK.almost_full_flag   = af_r;
  assign LINK.mail_one_flag      = 1'b1;
  assign LINK.mail_two_flag      = 1'b1;
  assign EMPTY_OFFSET            = empty_off_r;
  assign FULL_OFFSET             = full_off_r;
  assign OFFSET_MODE             = mode_r;

endmodule // dcff_device

// ---- design/dcff_host.sv ----
// Purpose: controller end driving the fifo link from a register port
// Assumes: software waits for ready flags before push and pop
// Notes: port a always writes, port b always reads
`timescale 1ns/100ps
`include "dcff_map.svh"
module dcff_host
  import dcff_pkg::*;
(
  // clock and reset
  input  wire logic              CLK,
  input  wire logic              RESET_N,
  // register port
  input  wire logic [7:0]        ADDR,
  input  wire logic [`DCFF_DW-1:0] WDATA,
  input  wire logic              WR,
  input  wire logic              RD,
  output logic [`DCFF_DW-1:0]    RDATA,
  // fifo link
  dcff_if.host                   LINK
);
  //////////////////////////////////////////////////////////////////////////////
  // declarations
  logic [2:0]           ctrl_r;
  logic [2:0]           hold_r;
  logic                 frst_n_r;
  logic [19:0]          ser_r;
  logic [4:0]           ser_cnt_r;
  logic                 ser_busy;
  logic                 a_stb_r;
  logic [`DCFF_DW-1:0]  a_dout_r;
  logic                 b_stb_r;
  logic [`DCFF_DW-1:0]  b_word_r;
  logic [`DCFF_DW-1:0]  rdata_r;

  // clamp one offset into the legal range
  function automatic logic [9:0] clamp(input logic [9:0] v);
    clamp = (v < `DCFF_OFF_MIN) ? `DCFF_OFF_MIN : ((v > `DCFF_OFF_MAX) ? `DCFF_OFF_MAX : v);
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // control register: bit0 sel0, bit1 sel1, bit2 release fifo reset
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ctrl_r <= 3'h0;
    end else if (WR && ADDR == `DCFF_REG_CTRL) begin
      ctrl_r <= WDATA[2:0];
    end
  end

  // fifo reset held low for at least four edges
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      hold_r   <= 3'h0;
      frst_n_r <= 1'b0;
    end else if (!ctrl_r[2]) begin
      hold_r   <= 3'h0;
      frst_n_r <= 1'b0;
    end else if (hold_r != `DCFF_RST_HOLD) begin
      hold_r   <= hold_r + 3'h1;
    end else begin
      frst_n_r <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // serial offset shifter, full msb first, empty lsb last
  assign ser_busy = (ser_cnt_r != 5'h00);
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ser_r     <= 20'h00000;
      ser_cnt_r <= 5'h00;
    end else if (ser_busy) begin
      ser_r     <= {ser_r[18:0], 1'b0};
      ser_cnt_r <= ser_cnt_r - 5'h01;
    end else if (WR && ADDR == `DCFF_REG_SER && frst_n_r) begin
      ser_r     <= {clamp(WDATA[19:10]), clamp(WDATA[9:0])};
      ser_cnt_r <= `DCFF_SER_BITS;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // push and pop strobes
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      a_stb_r  <= 1'b0;
      a_dout_r <= {`DCFF_DW{1'b0}};
      b_stb_r  <= 1'b0;
    end else begin
      a_stb_r  <= WR && ADDR == `DCFF_REG_PUSH;
      b_stb_r  <= WR && ADDR == `DCFF_REG_POP;
      if (WR && ADDR == `DCFF_REG_PUSH) begin
        a_dout_r <= WDATA;
      end
    end
  end

  // port b word sampled every cycle
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      b_word_r <= {`DCFF_DW{1'b0}};
    end else begin
      b_word_r <= LINK.port_b_bus;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // read decode, data one cycle after the strobe
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rdata_r <= {`DCFF_DW{1'b0}};
    end else if (RD) begin
      if (ADDR == `DCFF_REG_CTRL) begin
        rdata_r <= {33'h0, ctrl_r};
      end else if (ADDR == `DCFF_REG_DATA) begin
        rdata_r <= b_word_r;
      end else if (ADDR == `DCFF_REG_STAT) begin
        rdata_r <= {28'h0, frst_n_r, ser_busy, LINK.mail_two_flag, LINK.mail_one_flag,
                    LINK.almost_full_flag, LINK.almost_empty_flag,
                    LINK.output_ready_flag, LINK.input_ready_flag};
      end else begin
        rdata_r <= {`DCFF_DW{1'b0}};
      end
    end else begin
      rdata_r <= {`DCFF_DW{1'b0}};
    end
  end
  assign RDATA = rdata_r;

  //////////////////////////////////////////////////////////////////////////////
  // link pins
  assign LINK.fifo_rst_n              = frst_n_r;
  assign LINK.flag_sel0_serial_data   = ser_busy ? ser_r[19] : ctrl_r[0];
  assign LINK.flag_sel1_serial_load_n = ser_busy ? 1'b0 : ctrl_r[1];
  assign LINK.port_a_select_n         = 1'b0;
  assign LINK.port_a_write_not_read   = 1'b1;
  assign LINK.port_a_strobe           = a_stb_r;
  assign LINK.port_a_mail_select      = 1'b0;
  assign LINK.a_host_dout             = a_dout_r;
  assign LINK.a_host_oe               = 1'b1;
  assign LINK.port_b_select_n         = 1'b0;
  assign LINK.port_b_write_not_read   = 1'b1;
  assign LINK.port_b_strobe           = b_stb_r;
  assign LINK.port_b_mail_select      = 1'b0;
  assign LINK.b_host_dout             = {`DCFF_DW{1'b0}};
  assign LINK.b_host_oe               = 1'b0;

endmodule // dcff_host

// ---- testbench/dcff_checker.sv ----
// Purpose: assertions on the fifo link between device and controller
// Assumes: one clock for both ports, fifo reset driven by the controller
// Notes: straps are captured while the fifo is held in reset
`timescale 1ns/100ps
`include "dcff_map.svh"
module dcff_checker
  import dcff_pkg::*;
(
  // clock and resets
  input wire logic                CLK,
  input wire logic                RESET_N,
  input wire logic                fifo_rst_n,
  // straps
  input wire logic                flag_sel0_serial_data,
  input wire logic                flag_sel1_serial_load_n,
  // port a
  input wire logic                port_a_select_n,
  input wire logic                port_a_write_not_read,
  input wire logic                port_a_strobe,
  input wire logic                port_a_mail_select,
  input wire logic [`DCFF_DW-1:0] port_a_bus,
  input wire logic                a_dev_oe,
  // port b
  input wire logic                port_b_select_n,
  input wire logic                port_b_write_not_read,
  input wire logic                port_b_strobe,
  input wire logic                port_b_mail_select,
  input wire logic [`DCFF_DW-1:0] b_dev_dout,
  input wire logic                b_dev_oe,
  // flags
  input wire logic                input_ready_flag,
  input wire logic                output_ready_flag,
  input wire logic                almost_empty_flag,
  input wire logic                almost_full_flag
);
  logic       wr_acc;
  logic       rd_acc;
  logic [1:0] mode_r;
  logic [4:0] bits_r;
  logic [1:0] pload_r;

  // transfers taken at this edge
  assign wr_acc = !port_a_select_n && !port_a_mail_select && port_a_write_not_read && port_a_strobe && input_ready_flag;
  assign rd_acc = !port_b_select_n && !port_b_mail_select && port_b_write_not_read && port_b_strobe && output_ready_flag;

  // strap capture, serial bit count, offset write count
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      mode_r  <= 2'h0;
      bits_r  <= 5'h00;
      pload_r <= 2'h0;
    end else if (!fifo_rst_n) begin
      mode_r  <= {flag_sel1_serial_load_n, flag_sel0_serial_data};
      bits_r  <= 5'h00;
      pload_r <= (flag_sel1_serial_load_n | flag_sel0_serial_data) ? 2'h2 : 2'h0;
    end else begin
      if (mode_r == OM_SERIAL && !flag_sel1_serial_load_n && bits_r != `DCFF_SER_BITS)
        bits_r <= bits_r + 5'h01;
      if (wr_acc && pload_r != `DCFF_PLOAD_N)
        pload_r <= pload_r + 2'h1;
    end
  end

  ////////////////////////////////////////////////////////////////
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N || !fifo_rst_n);

  // ready low two samples, then high
  sequence s_ir_late;
    !input_ready_flag [*2] ##1 input_ready_flag;
  endsequence
  // written word hidden four samples, then shown
  sequence s_word_lands;
    !output_ready_flag [*4] ##1 (output_ready_flag && b_dev_dout == $past(port_a_bus, 4));
  endsequence

  a_a_bus_drive: assert property (a_dev_oe == (!port_a_select_n && !port_a_write_not_read))
    else $error("port a drive enable wrong");
  a_b_bus_drive: assert property (b_dev_oe == (!port_b_select_n && port_b_write_not_read))
    else $error("port b drive enable wrong");
  a_reset_flags: assert property (disable iff (!RESET_N) !fifo_rst_n ##1 !fifo_rst_n |->
    !input_ready_flag && !output_ready_flag && !almost_empty_flag && almost_full_flag)
    else $error("flag levels wrong in reset");
  a_preset_ready: assert property ($rose(fifo_rst_n) && !(flag_sel0_serial_data && flag_sel1_serial_load_n)
    |-> s_ir_late) else $error("ready not two edges after release");
  a_first_word: assert property (wr_acc && pload_r == 2'h2 && !output_ready_flag && !$past(wr_acc)
    && !$past(wr_acc, 2) && !$past(wr_acc, 3) |-> s_word_lands) else $error("first word late or wrong");
  a_read_frees: assert property (rd_acc && !input_ready_flag |=> s_ir_late)
    else $error("ready not on second edge after read");
  a_or_hold: assert property (!output_ready_flag ##1 !output_ready_flag |-> $stable(b_dev_dout))
    else $error("output register changed while not ready");
  a_serial_hold: assert property (mode_r == OM_SERIAL && bits_r != `DCFF_SER_BITS |-> !input_ready_flag)
    else $error("ready before all serial bits");
  a_serial_done: assert property (mode_r == OM_SERIAL && !flag_sel1_serial_load_n && bits_r == 5'h13
    |-> s_ir_late) else $error("ready not after last serial bit");
endmodule // dcff_checker

// ---- testbench/tb_dual_clock_fwft_fifo_core.sv ----
// Purpose: self-checking bench of controller and device joined by the link
// Assumes: one clock, register port of the controller drives all traffic
// Notes: a queue model predicts every word read back
`timescale 1ns/100ps
`include "dcff_map.svh"
module tb_dual_clock_fwft_fifo_core;
  import dcff_pkg::*;
  logic                clk;
  logic                reset_n;
  logic [7:0]          addr;
  logic [`DCFF_DW-1:0] wdata;
  logic                wr;
  logic                rd;
  logic [`DCFF_DW-1:0] rdata;
  logic [9:0]          empty_off;
  logic [9:0]          full_off;
  logic [1:0]          off_mode;
  logic [`DCFF_DW-1:0] v;
  logic [`DCFF_DW-1:0] st;
  logic [`DCFF_DW-1:0] q[$];
  logic [9:0]          fo;
  logic [9:0]          eo;
  int                  error_cnt;
  int                  cmp_count;
  int                  cyc;
  int                  seed;
  int                  n;

  dcff_if lk ();
  dcff_device u_dcff_device (.CLK(clk), .RESET_N(reset_n), .LINK(lk), .EMPTY_OFFSET(empty_off),
    .FULL_OFFSET(full_off), .OFFSET_MODE(off_mode));
  dcff_host u_dcff_host (.CLK(clk), .RESET_N(reset_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .LINK(lk));
  dcff_checker u_dcff_checker (.CLK(clk), .RESET_N(reset_n), .fifo_rst_n(lk.fifo_rst_n),
    .flag_sel0_serial_data(lk.flag_sel0_serial_data), .flag_sel1_serial_load_n(lk.flag_sel1_serial_load_n),
    .port_a_select_n(lk.port_a_select_n), .port_a_write_not_read(lk.port_a_write_not_read),
    .port_a_strobe(lk.port_a_strobe), .port_a_mail_select(lk.port_a_mail_select), .port_a_bus(lk.port_a_bus),
    .a_dev_oe(lk.a_dev_oe), .port_b_select_n(lk.port_b_select_n), .port_b_write_not_read(lk.port_b_write_not_read),
    .port_b_strobe(lk.port_b_strobe), .port_b_mail_select(lk.port_b_mail_select), .b_dev_dout(lk.b_dev_dout),
    .b_dev_oe(lk.b_dev_oe), .input_ready_flag(lk.input_ready_flag), .output_ready_flag(lk.output_ready_flag),
    .almost_empty_flag(lk.almost_empty_flag), .almost_full_flag(lk.almost_full_flag));

  // clock and hang guard
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      error_cnt++;
      finish_test();
    end
  end

  ////////////////////////////////////////////////////////////////
  task finish_test();
    if (error_cnt == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task chk(input string nm, input logic [35:0] exp, input logic [35:0] got);
    cmp_count++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
      error_cnt++;
    end
  endtask
  // one-cycle register write and read
  task reg_wr(input logic [7:0] a, input logic [35:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task reg_rd(input logic [7:0] a, output logic [35:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask
  // push random words until full or limit
  task fill(input int lim);
    n = 0;
    do begin
      v = {4'($random(seed)), 32'($random(seed))};
      reg_wr(`DCFF_REG_PUSH, v);
      q.push_back(v);
      n++;
      reg_rd(`DCFF_REG_STAT, st);
    end while (st[0] === 1'b1 && n < lim);
  endtask
  // read head, compare with model, pop
  task drain();
    repeat (6) @(posedge clk);
    while (q.size() > 0) begin
      reg_rd(`DCFF_REG_DATA, v);
      chk("data", q.pop_front(), v);
      reg_wr(`DCFF_REG_POP, 36'h0);
      @(posedge clk); // data register lags the output register by one edge
    end
  endtask

  // main sequence
  initial begin
    clk = 1'b0;
    reset_n = 1'b0;
    addr = 8'h00;
    wdata = 36'h0;
    wr = 1'b0;
    rd = 1'b0;
    error_cnt = 0;
    cmp_count = 0;
    cyc = 0;
    seed = 51;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    reg_rd(8'hFC, v);
    chk("unmapped", 36'h0, v);
    for (int m = 0; m < 4; m++) begin
      fo = 10'(1 + ({$random(seed)} % 1020));
      eo = 10'(1 + ({$random(seed)} % 1020));
      reg_wr(`DCFF_REG_CTRL, 36'(m));
      reg_rd(`DCFF_REG_STAT, v);
      chk("status_rst", 36'h38, {28'h0, v[7:0]});
      reg_wr(`DCFF_REG_CTRL, 36'(m + 4));
      repeat (8) @(posedge clk);
      chk("mode", 36'(m), {34'h0, off_mode});
      if (m == 0) begin
        reg_wr(`DCFF_REG_PUSH, {26'($random(seed)), fo});
        reg_wr(`DCFF_REG_PUSH, {26'($random(seed)), eo});
      end else if (m == 3) begin
        reg_wr(`DCFF_REG_SER, {16'h0, fo, eo});
        repeat (30) @(posedge clk);
      end else begin
        fo = (m == 1) ? `DCFF_PRE_LOW : `DCFF_PRE_HIGH;
        eo = fo;
      end
      repeat (4) @(posedge clk);
      chk("full_off", 36'(fo), 36'(full_off));
      chk("empty_off", 36'(eo), 36'(empty_off));
      reg_rd(`DCFF_REG_STAT, v);
      chk("status_run", 36'hB9, {28'h0, v[7:0]});
      fill(3);
      drain();
    end
    fill(1100);
    chk("fill_cnt", 36'h401, 36'(n));
    // one more push while full is dropped
    reg_wr(`DCFF_REG_PUSH, 36'h0);
    repeat (6) @(posedge clk);
    reg_rd(`DCFF_REG_STAT, v);
    chk("status_full", 36'hB6, {28'h0, v[7:0]});
    drain();
    // pop with nothing ready is ignored
    reg_wr(`DCFF_REG_POP, 36'h0);
    repeat (6) @(posedge clk);
    reg_rd(`DCFF_REG_STAT, v);
    chk("status_empty", 36'hB9, {28'h0, v[7:0]});
    finish_test();
  end
endmodule // tb_dual_clock_fwft_fifo_core
